// file: design/sdl_pkg.sv
package sdl_pkg;

  // ****************************************************************
  // Word format
  // ****************************************************************
  localparam int WORD_BITS = 16;
  localparam int CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_BITS-1:0] CNT_RESET = 5'h00;
  localparam int MSB_POS = 15;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [WORD_BITS-1:0] CONV_RESET = 16'h0000;
  localparam logic [WORD_BITS-1:0] MIDSCALE = 16'h8000;

  // Output level is signed, in steps of one reference over 65,536
  localparam int LEVEL_BITS = 18;
  localparam logic signed [LEVEL_BITS-1:0] LEVEL_RESET = 18'sh00000;

  // Idle levels the pin filters start from
  localparam logic SEL_IDLE = 1'b1;
  localparam logic SCLK_IDLE = 1'b0;
  localparam logic DATA_IDLE = 1'b0;
  localparam logic LOAD_IDLE = 1'b1;

  // ****************************************************************
  // Frame tracking
  // ****************************************************************
  typedef enum logic [0:0] {
    FR_IDLE = 1'b0,
    FR_SHIFT = 1'b1
  } sdl_frame_e;

endpackage

// file: design/sdl_pin_filter.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; the output moves only once stages two and three agree
module sdl_pin_filter #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);

  logic meta_r;
  logic sync_r;
  logic hold_r;

  // ****************************************************************
  // Synchroniser chain
  // ****************************************************************
  // First stage feeds only the second, to keep metastability contained
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= INIT;
      sync_r <= INIT;
      hold_r <= INIT;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      hold_r <= sync_r;
    end
  end

  // Accepted level, changes when two settled stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= INIT;
    end else if (sync_r == hold_r) begin
      level <= hold_r;
    end
  end

endmodule

// file: design/sdl_word_loader.sv
`timescale 1ns/1ps
module sdl_word_loader (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  input wire logic FRAME_SEL_N,
  input wire logic CONVERTER_LOAD_STROBE_N,
  input wire logic BIPOLAR_MODE,
  output logic [sdl_pkg::WORD_BITS-1:0] CONV_CODE,
  output logic signed [sdl_pkg::LEVEL_BITS-1:0] OUT_LEVEL,
  output logic LOAD_PULSE,
  output logic FRAME_ACTIVE,
  output logic WORD_COMPLETE
);
  import sdl_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Edge test shared by the clock, select and strobe pins
  function automatic logic rising(input logic prev, input logic cur);
    rising = !prev && cur;
  endfunction

  // Code to signed output step count; bipolar steps are twice as large
  function automatic logic signed [LEVEL_BITS-1:0] code_to_level(
    input logic [WORD_BITS-1:0] code,
    input logic bipolar
  );
    logic signed [LEVEL_BITS-1:0] offs;
    offs = $signed({2'b00, code}) - $signed({2'b00, MIDSCALE});
    if (bipolar) begin
      code_to_level = offs <<< 1;
    end else begin
      code_to_level = $signed({2'b00, code});
    end
  endfunction

  // ****************************************************************
  // Pin filters
  // ****************************************************************
  logic sclk_lvl;
  logic data_lvl;
  logic sel_lvl;
  logic load_lvl;
  logic mode_lvl;

  // Data goes through the same depth as the clock so they stay aligned
  sdl_pin_filter #(.INIT(SCLK_IDLE)) u_sclk (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .pin(SER_CLK),
    .level(sclk_lvl)
  );

  sdl_pin_filter #(.INIT(DATA_IDLE)) u_data (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .pin(SER_DATA),
    .level(data_lvl)
  );

  sdl_pin_filter #(.INIT(SEL_IDLE)) u_sel (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .pin(FRAME_SEL_N),
    .level(sel_lvl)
  );

  sdl_pin_filter #(.INIT(LOAD_IDLE)) u_load (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .pin(CONVERTER_LOAD_STROBE_N),
    .level(load_lvl)
  );

  // Mode is a strap-like level; filtered like the others
  sdl_pin_filter #(.INIT(1'b0)) u_mode (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .pin(BIPOLAR_MODE),
    .level(mode_lvl)
  );

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  logic sclk_prev_r;
  logic sel_prev_r;
  logic load_prev_r;

  // Previous filtered levels, for edge finding
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      sclk_prev_r <= SCLK_IDLE;
      sel_prev_r <= SEL_IDLE;
      load_prev_r <= LOAD_IDLE;
    end else begin
      sclk_prev_r <= sclk_lvl;
      sel_prev_r <= sel_lvl;
      load_prev_r <= load_lvl;
    end
  end

  logic sclk_rise;
  logic sel_rise;
  logic sel_fall;
  logic load_fall;

  // Only rising serial clock edges sample; inverted host clocks arrive here already flipped
  assign sclk_rise = rising(sclk_prev_r, sclk_lvl);
  assign sel_rise = rising(sel_prev_r, sel_lvl);
  assign sel_fall = rising(sel_lvl, sel_prev_r);
  assign load_fall = rising(load_lvl, load_prev_r);

  // ****************************************************************
  // Frame state
  // ****************************************************************
  sdl_frame_e frame_r;
  sdl_frame_e frame_nxt;

  // A frame runs from the select fall to the select rise
  always_comb begin
    frame_nxt = frame_r;
    case (frame_r)
      FR_IDLE: begin
        if (sel_fall) begin
          frame_nxt = FR_SHIFT;
        end
      end
      FR_SHIFT: begin
        if (sel_rise) begin
          frame_nxt = FR_IDLE;
        end
      end
      default: begin
        frame_nxt = FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      frame_r <= FR_IDLE;
    end else begin
      frame_r <= frame_nxt;
    end
  end

  // ****************************************************************
  // Bit counter
  // ****************************************************************
  logic [CNT_BITS-1:0] bits_r;
  logic shift_en;

  // Shifting only while selected; idle clocking is ignored
  assign shift_en = sclk_rise && !sel_lvl;

  // Counts the bits of the current frame, saturating at a full word
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      bits_r <= CNT_RESET;
    end else if (sel_fall) begin
      bits_r <= CNT_RESET;
    end else if (shift_en && bits_r != CNT_FULL) begin
      bits_r <= bits_r + 5'h01;
    end
  end

  // ****************************************************************
  // Shift register
  // ****************************************************************
  logic [WORD_BITS-1:0] shift_r;

  // No reset here on purpose: the content is undefined until bits arrive
  always_ff @(posedge CLK_SYS) begin
    if (shift_en) begin
      // First bit ends up at the top; longer frames push older bits out
      shift_r <= {shift_r[MSB_POS-1:0], data_lvl};
    end
  end

  // ****************************************************************
  // Converter register
  // ****************************************************************
  logic load_now;
  logic word_held_r;

  // Strobe low at select rise loads at once; strobe high defers to its fall
  // A strobe fall counts only with a deferred word waiting, so a strobe tied low
  // from power-up cannot copy the undefined shift register once reset ends
  assign load_now = (sel_rise && !load_lvl) || (load_fall && sel_lvl && word_held_r);

  // Deferred word marker: set by a select rise with strobe high, cleared by its load
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      word_held_r <= 1'b0;
    end else if (sel_rise && load_lvl) begin
      word_held_r <= 1'b1;
    end else if (load_now) begin
      word_held_r <= 1'b0;
    end
  end

  // Short frames still transfer, carrying bits of the previous word
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      CONV_CODE <= CONV_RESET;
    end else if (load_now) begin
      CONV_CODE <= shift_r;
    end
  end

  // Transfer marker, one cycle per load
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      LOAD_PULSE <= 1'b0;
    end else begin
      LOAD_PULSE <= load_now;
    end
  end

  // ****************************************************************
  // Output level
  // ****************************************************************
  // Tracks the held code and mode one cycle later; reset shows zero code unipolar
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      OUT_LEVEL <= LEVEL_RESET;
    end else begin
      OUT_LEVEL <= code_to_level(CONV_CODE, mode_lvl);
    end
  end

  // ****************************************************************
  // Status
  // ****************************************************************
  // Frame and word-length flags for the surrounding logic
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      FRAME_ACTIVE <= 1'b0;
      WORD_COMPLETE <= 1'b0;
    end else begin
      FRAME_ACTIVE <= (frame_nxt == FR_SHIFT);
      WORD_COMPLETE <= (bits_r == CNT_FULL);
    end
  end

endmodule

// file: test/sdl_word_loader_checker.sv
`timescale 1ns/1ps
// Pin-level watch on the word loader; a single clock domain, so clocking is shared
module sdl_word_loader_checker (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic FRAME_SEL_N,
  input wire logic CONVERTER_LOAD_STROBE_N,
  input wire logic BIPOLAR_MODE,
  input wire logic [sdl_pkg::WORD_BITS-1:0] CONV_CODE,
  input wire logic signed [sdl_pkg::LEVEL_BITS-1:0] OUT_LEVEL,
  input wire logic LOAD_PULSE,
  input wire logic FRAME_ACTIVE,
  input wire logic WORD_COMPLETE
);
  import sdl_pkg::*;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  // Windows of 8 cycles cover the pin filter delay of about 5 edges
  a_reset_clear: assert property ($rose(RST_N) |-> CONV_CODE == CONV_RESET && OUT_LEVEL == LEVEL_RESET)
    else $error("code not clear after reset");
  a_code_on_load: assert property ($changed(CONV_CODE) |-> LOAD_PULSE)
    else $error("code moved without load");
  a_pulse_single: assert property (LOAD_PULSE |=> !LOAD_PULSE)
    else $error("load pulse too long");
  a_select_rise_load: assert property ($rose(FRAME_SEL_N) && !CONVERTER_LOAD_STROBE_N |-> ##[3:8] LOAD_PULSE)
    else $error("no load after select rise");
  a_strobe_fall_load: assert property (FRAME_SEL_N[*8] ##0 $fell(CONVERTER_LOAD_STROBE_N) |-> ##[3:8] LOAD_PULSE)
    else $error("no load after strobe fall");
  a_idle_no_load: assert property ((FRAME_SEL_N && CONVERTER_LOAD_STROBE_N)[*8] |-> !LOAD_PULSE)
    else $error("load while idle");
  a_frame_open: assert property ((!FRAME_SEL_N)[*8] |-> FRAME_ACTIVE)
    else $error("frame not seen");
  a_frame_closed: assert property (FRAME_SEL_N[*8] |-> !FRAME_ACTIVE && $stable(WORD_COMPLETE))
    else $error("activity outside frame");
  a_unipolar_map: assert property ((!BIPOLAR_MODE)[*8] ##1 !(BIPOLAR_MODE || LOAD_PULSE)
    |-> OUT_LEVEL == $signed({2'b00, CONV_CODE})) else $error("unipolar level wrong");
  a_bipolar_map: assert property (BIPOLAR_MODE[*8] ##1 (BIPOLAR_MODE && !LOAD_PULSE)
    |-> OUT_LEVEL == $signed({{2{~CONV_CODE[15]}}, CONV_CODE[14:0], 1'b0})) else $error("bipolar level wrong");
  c_bipolar_load: cover property (LOAD_PULSE && BIPOLAR_MODE);
  c_strobe_fall: cover property ($fell(CONVERTER_LOAD_STROBE_N) && FRAME_SEL_N);
  c_word_done: cover property ($rose(WORD_COMPLETE));
endmodule
bind sdl_word_loader sdl_word_loader_checker u_checker (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .FRAME_SEL_N(FRAME_SEL_N), .CONVERTER_LOAD_STROBE_N(CONVERTER_LOAD_STROBE_N), .BIPOLAR_MODE(BIPOLAR_MODE),
  .CONV_CODE(CONV_CODE), .OUT_LEVEL(OUT_LEVEL), .LOAD_PULSE(LOAD_PULSE), .FRAME_ACTIVE(FRAME_ACTIVE),
  .WORD_COMPLETE(WORD_COMPLETE));

// file: test/sdl_host_model.sv
`timescale 1ns/1ps
// Host serial master; one serial clock period is 8 system cycles (200 ns)
module sdl_host_model (
  input wire logic clk,
  output logic sclk,
  output logic sdata,
  output logic sel_n,
  output logic load_n
);
  // Clock parked low between frames, only one device ever selected
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    sel_n = 1'b1;
    load_n = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Low n bits of w, top first; for n of 8 or more, one pause after the first 8 bits, with select held across it
  task automatic xfer(input logic [31:0] w, input int n);
    gap(8);
    sel_n <= 1'b0;
    gap(4);
    for (int i = n - 1; i >= 0; i--) begin
      sdata <= w[i];
      gap(4);
      sclk <= 1'b1;
      gap(4);
      sclk <= 1'b0;
      if (i == n - 8) gap(16);
    end
    gap(4);
    sel_n <= 1'b1;
    sdata <= ~sdata; // Released line must not keep its last bit
  endtask
  // Shared-bus traffic while this device is deselected
  task automatic noise(input int n);
    for (int i = 0; i < n; i++) begin
      sdata <= ~sdata;
      gap(4);
      sclk <= ~sclk;
      gap(4);
    end
  endtask
  task automatic strobe(input logic v);
    @(posedge clk);
    load_n <= v;
  endtask
endmodule

// file: test/test_sdl_word_loader.sv
`timescale 1ns/1ps
module test_sdl_word_loader;
  import sdl_pkg::*;
  logic CLK_SYS, RST_N, BIPOLAR_MODE, sclk, sdata, sel_n, load_n, load_pulse, frame_active, word_complete;
  logic [WORD_BITS-1:0] conv_code;
  logic signed [LEVEL_BITS-1:0] out_level;
  int mismatches = 0;
  int checks = 0;
  sdl_word_loader DUT (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SER_CLK(sclk), .SER_DATA(sdata), .FRAME_SEL_N(sel_n),
    .CONVERTER_LOAD_STROBE_N(load_n), .BIPOLAR_MODE(BIPOLAR_MODE), .CONV_CODE(conv_code), .OUT_LEVEL(out_level),
    .LOAD_PULSE(load_pulse), .FRAME_ACTIVE(frame_active), .WORD_COMPLETE(word_complete));
  sdl_host_model host (.clk(CLK_SYS), .sclk(sclk), .sdata(sdata), .sel_n(sel_n), .load_n(load_n));
  // 40 MHz system clock
  initial begin
    CLK_SYS = 1'b0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Codes are zero extended so one compare serves codes and levels
  task automatic cmp_val(input string what, input logic [17:0] exp, input logic [17:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_flag(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask
  // Watches 40 cycles on falling edges, where outputs have settled; a missing load ends the run
  task automatic wait_load(input logic want);
    logic seen;
    seen = 1'b0;
    repeat (40) begin
      @(negedge CLK_SYS);
      if (load_pulse === 1'b1) seen = 1'b1;
    end
    cmp_flag("load pulse", want, seen);
    if (want && !seen) conclude();
  endtask
  task automatic t_first_word();
    cmp_val("reset code", 18'h00000, {2'b00, conv_code});
    cmp_val("reset level", 18'h00000, out_level);
    host.xfer(32'h0000a5c3, 16);
    wait_load(1'b1);
    cmp_val("first word", 18'h0a5c3, {2'b00, conv_code});
    cmp_flag("word complete", 1'b1, word_complete);
    cmp_flag("frame closed", 1'b0, frame_active);
  endtask
  // Every row of both code tables, each checked in both modes
  task automatic t_code_table();
    logic [15:0] tbl [6] = '{16'hffff, 16'h8000, 16'h0001, 16'h0000, 16'h8001, 16'h7fff};
    for (int k = 0; k < 6; k++) begin
      host.xfer({16'h0000, tbl[k]}, 16);
      wait_load(1'b1);
      @(posedge CLK_SYS);
      BIPOLAR_MODE <= 1'b0;
      repeat (10) @(negedge CLK_SYS);
      cmp_val("unipolar level", 18'(int'(tbl[k])), out_level);
      @(posedge CLK_SYS);
      BIPOLAR_MODE <= 1'b1;
      repeat (10) @(negedge CLK_SYS);
      cmp_val("bipolar level", 18'(2 * (int'(tbl[k]) - 32768)), out_level);
    end
  endtask
  task automatic t_odd_lengths();
    host.xfer({16'h0000, 12'habc, 4'h0}, 16);
    wait_load(1'b1);
    cmp_val("padded word", 18'h0abc0, {2'b00, conv_code});
    host.xfer(32'h00031234, 20);
    wait_load(1'b1);
    cmp_val("long frame", 18'h01234, {2'b00, conv_code});
    host.xfer(32'h0000000f, 4);
    wait_load(1'b1);
    cmp_val("short frame", 18'h0234f, {2'b00, conv_code});
    cmp_flag("short complete", 1'b0, word_complete);
  endtask
  task automatic t_deselected();
    host.noise(16);
    wait_load(1'b0);
    cmp_val("deselected", 18'h0234f, {2'b00, conv_code});
    // A short frame now shows whether the noise moved the shift register
    host.xfer(32'h00000005, 4);
    wait_load(1'b1);
    cmp_val("shift kept", 18'h034f5, {2'b00, conv_code});
  endtask
  // Strobe high at select rise must defer the load until it falls
  task automatic t_strobe_load();
    host.strobe(1'b1);
    host.xfer(32'h00000f0f, 16);
    wait_load(1'b0);
    cmp_val("deferred", 18'h034f5, {2'b00, conv_code});
    host.strobe(1'b0);
    wait_load(1'b1);
    cmp_val("strobed", 18'h00f0f, {2'b00, conv_code});
  endtask
  // Reset for 3 cycles, then the scenarios in turn
  initial begin
    RST_N = 1'b0;
    BIPOLAR_MODE = 1'b0;
    repeat (3) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    // Long enough for a false strobe edge after reset to reach the code
    repeat (12) @(negedge CLK_SYS);
    t_first_word();
    t_code_table();
    t_odd_lengths();
    t_deselected();
    t_strobe_load();
    conclude();
  end
endmodule
